// ===== dv/mfp_isa_host.sv
`timescale 1ns/100ps
module mfp_isa_host (
    input  wire logic        clk_i,
    output logic      [15:0] isa_addr_o,
    output logic             cs_n_o,
    output logic             rd_n_o,
    output logic             wr_n_o
);
    initial begin
        {isa_addr_o, cs_n_o, rd_n_o, wr_n_o} = {16'hffff, 3'b111};
    end

    // full 16-bit address driven; select held low for the whole cycle
    task automatic start(input logic [15:0] a, input logic rd);
        @(posedge clk_i);
        isa_addr_o <= a;
        {cs_n_o, rd_n_o, wr_n_o} <= {1'b0, !rd, rd};
    endtask : start

    // strobes idle high; a released address bus is not left at its value
    task automatic stop();
        @(posedge clk_i);
        {cs_n_o, rd_n_o, wr_n_o} <= 3'b111;
        isa_addr_o <= ~isa_addr_o;
    endtask : stop
endmodule : mfp_isa_host

// ===== dv/mfp_top_bench.sv
`timescale 1ns/100ps
module mfp_top_bench;
    import mfp_pkg::*;
    // ========================================
    // pins
    logic clk_i = 1'b0, rst_i = 1'b1, standby_rst_i = 1'b1, ce_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic supply_good_i = 1'b1, config_base_strap_i = 1'b0;
    logic [15:0] isa_addr_i;
    logic chip_select_n_i, isa_rd_n_i, isa_wr_n_i;
    logic cfg_port_hit_o, host_rd_o, host_wr_o;
    logic dma3_ack_pin_i = 1'b0, dma3_request_i = 1'b1;
    logic dma3_req_pin_o, dma3_req_pin_oe_o, dma3_ack_pin_o;
    logic dma3_ack_pin_oe_o, dma3_acknowledge_n_o;
    logic port2_ri_pin_i = 1'b0, port2_dcd_pin_i = 1'b0;
    logic port2_ri_pin_o, port2_ri_pin_oe_o, port2_dcd_pin_o;
    logic port2_dcd_pin_oe_o, port2_ring_indicate_n_o;
    logic port2_carrier_detect_n_o, kbc_port_line_a_o, kbc_port_line_b_o;
    logic kbc_port_line_a_i = 1'b1, kbc_port_line_b_i = 1'b0;
    logic port2_rx_pin_i = 1'b0, uart2_tx_i = 1'b0, infrared_transmit_i = 1'b1;
    logic port2_tx_pin_o, port2_receive_o, infrared_receive_o;
    logic port2_set_ready_pin_i = 1'b0, port2_clear_send_pin_i = 1'b0;
    logic port2_request_send_pin_i = 1'b0, port2_terminal_ready_pin_i = 1'b0;
    logic port2_request_send_n_i = 1'b0, port2_terminal_ready_n_i = 1'b0;
    logic port2_request_send_pin_o, port2_request_send_pin_oe_o;
    logic port2_terminal_ready_pin_o, port2_terminal_ready_pin_oe_o;
    logic port2_set_ready_n_o, port2_clear_send_n_o;
    logic keyboard_data_line_i = 1'b1, mouse_data_line_i = 1'b1;
    logic port1_ring_indicate_n_i = 1'b1, wake_enable_i = 1'b0;
    logic wake_event_out_n_o, pll_power_o, keyboard_reset_out_n_o;
    int num_errors = 0, check_count = 0;
    logic [7:0] obs;
    // rows: control value, then expected routed pins
    logic [15:0] rows [8] = '{16'h1005, 16'h0187, 16'h0247, 16'h0437,
                              16'h080b, 16'h2005, 16'h4006, 16'h03c7};
    assign obs = {dma3_acknowledge_n_o, port2_ring_indicate_n_o,
                  port2_receive_o, port2_tx_pin_o, port2_set_ready_n_o,
                  port2_request_send_pin_oe_o, pll_power_o,
                  keyboard_reset_out_n_o};

    mfp_isa_host i_mfp_isa_host (.clk_i(clk_i), .isa_addr_o(isa_addr_i),
        .cs_n_o(chip_select_n_i), .rd_n_o(isa_rd_n_i), .wr_n_o(isa_wr_n_i));
    mfp_top i_mfp_top (.*);

    always #50 clk_i = ~clk_i;

    // ========================================
    // tasks
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        // a missing answer counts as a mismatch
        if (wb_ack_o !== 1'b1) num_errors++;
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb

    task automatic chk(input string nm, input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test

    initial begin
        repeat (3000) @(posedge clk_i);
        num_errors++;
        finish_test();
    end

    // ========================================
    // sequence
    initial begin
        repeat (8) @(posedge clk_i);
        {rst_i, standby_rst_i} <= 2'b00;
        repeat (2) @(negedge clk_i);
        chk("reset pins", obs, 8'h05);
        wb(1'b0, MFP_CTRL_OFS, 32'h0);
        chk("reset ctrl", q, 32'h10);
        wb(1'b0, MFP_STATUS_OFS, 32'h0);
        chk("status", q, 32'h2);
        wb(1'b1, 8'h08, 32'hffff_ffff);
        wb(1'b0, 8'h08, 32'h0);
        chk("unmapped", q, 32'h0);
        foreach (rows[i]) begin
            wb(1'b1, MFP_CTRL_OFS, {24'h0, rows[i][15:8]});
            repeat (2) @(negedge clk_i);
            chk("pins", obs, rows[i][7:0]);
            wb(1'b0, MFP_CTRL_OFS, 32'h0);
            chk("ctrl", q, {24'h0, rows[i][15:8]});
        end
        chk("kbc pins", {dma3_req_pin_o, dma3_req_pin_oe_o, dma3_ack_pin_o,
            dma3_ack_pin_oe_o, port2_ri_pin_o, port2_ri_pin_oe_o,
            port2_dcd_pin_o, port2_dcd_pin_oe_o, port2_carrier_detect_n_o,
            kbc_port_line_a_o, kbc_port_line_b_o}, 11'h6be);
        wb(1'b1, MFP_CTRL_OFS, 32'h0);
        // clock enable low must freeze the routed pins
        @(posedge clk_i) {ce_i, port2_rx_pin_i} <= 2'b01;
        repeat (2) @(negedge clk_i);
        chk("frozen", port2_receive_o, 1'b0);
        @(posedge clk_i) ce_i <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk("thawed", port2_receive_o, 1'b1);
        chk("dma pins", {dma3_req_pin_o, dma3_req_pin_oe_o, dma3_ack_pin_oe_o,
            port2_ri_pin_oe_o, port2_dcd_pin_oe_o, kbc_port_line_a_o,
            kbc_port_line_b_o, port2_terminal_ready_pin_oe_o,
            port2_clear_send_n_o, infrared_receive_o}, 10'h31c);
        i_mfp_isa_host.start(MFP_CFG_BASE_LO, 1'b1);
        repeat (2) @(negedge clk_i);
        chk("decode lo", {host_rd_o, host_wr_o, cfg_port_hit_o}, 3'b101);
        i_mfp_isa_host.stop();
        wb(1'b1, MFP_CTRL_OFS, 32'h8);
        i_mfp_isa_host.start(MFP_CFG_BASE_LO, 1'b1);
        repeat (2) @(negedge clk_i);
        chk("dec16", {host_rd_o, host_wr_o, cfg_port_hit_o},
            3'b101);
        i_mfp_isa_host.stop();
        @(posedge clk_i) port2_request_send_pin_i <= 1'b1;
        i_mfp_isa_host.start(MFP_CFG_BASE_LO, 1'b1);
        repeat (2) @(negedge clk_i);
        chk("dec16 miss", {host_rd_o, host_wr_o, cfg_port_hit_o}, 0);
        i_mfp_isa_host.stop();
        @(posedge clk_i) supply_good_i <= 1'b0;
        i_mfp_isa_host.start(MFP_CFG_BASE_LO, 1'b0);
        repeat (2) @(negedge clk_i);
        chk("gated", {host_rd_o, host_wr_o, cfg_port_hit_o, pll_power_o}, 0);
        i_mfp_isa_host.stop();
        @(posedge clk_i) {port2_ri_pin_i, port2_rx_pin_i, wake_enable_i} <= 3'b111;
        repeat (2) @(negedge clk_i);
        chk("wake idle", wake_event_out_n_o, 1'b1);
        @(posedge clk_i) keyboard_data_line_i <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk("wake", wake_event_out_n_o, 1'b0);
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(negedge clk_i);
        chk("wake host rst", wake_event_out_n_o, 1'b0);
        @(posedge clk_i) {rst_i, standby_rst_i, config_base_strap_i} <= 3'b011;
        repeat (2) @(negedge clk_i);
        chk("wake standby", wake_event_out_n_o, 1'b1);
        @(posedge clk_i) {standby_rst_i, supply_good_i} <= 2'b01;
        i_mfp_isa_host.start(MFP_CFG_BASE_HI, 1'b0);
        repeat (2) @(negedge clk_i);
        chk("decode hi", {host_rd_o, host_wr_o, cfg_port_hit_o}, 3'b011);
        i_mfp_isa_host.stop();
        finish_test();
    end
endmodule : mfp_top_bench

bind mfp_top mfp_top_sva i_mfp_top_sva (.*);

// ===== dv/mfp_top_sva.sv
`timescale 1ns/100ps
module mfp_top_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic supply_good_i,
    input wire logic cfg_port_hit_o,
    input wire logic host_rd_o,
    input wire logic host_wr_o,
    input wire logic dma3_ack_pin_i,
    input wire logic dma3_acknowledge_n_o,
    input wire logic port2_ri_pin_oe_o,
    input wire logic port2_ring_indicate_n_o,
    input wire logic port2_receive_o,
    input wire logic infrared_receive_o,
    input wire logic port2_set_ready_n_o,
    input wire logic port2_request_send_pin_oe_o,
    input wire logic wake_enable_i,
    input wire logic keyboard_data_line_i,
    input wire logic wake_event_out_n_o,
    input wire logic pll_power_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ========================================
    // bus handshake
    sequence s_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_ack_pulse: assert property (s_taken |=> s_pulse)
        else $error("bus ack is not a one cycle answer");

    // ========================================
    // pin routing and gating
    a_host_gated: assert property (ce_i && !supply_good_i |=>
        !(cfg_port_hit_o || host_rd_o || host_wr_o))
        else $error("host decode active without supply good");
    a_pll_gated: assert property (!supply_good_i |=> !pll_power_o)
        else $error("pll powered without supply good");
    // the wake path must ignore host reset, so only standby reset masks it
    a_wake_raise: assert property (@(posedge clk_i)
        disable iff (standby_rst_i)
        ce_i && wake_enable_i && !keyboard_data_line_i |=> !wake_event_out_n_o)
        else $error("wake output missed a keyboard event");
    a_wake_quiet: assert property (@(posedge clk_i)
        disable iff (standby_rst_i)
        ce_i && !wake_enable_i |=> wake_event_out_n_o)
        else $error("wake output active while disabled");
    a_rx_route: assert property (infrared_receive_o |-> port2_receive_o)
        else $error("receive fed to both uart and infrared");
    a_addr_mode: assert property (
        !port2_set_ready_n_o |-> port2_request_send_pin_oe_o)
        else $error("modem input live while pins are address");
    a_kbc_ring: assert property (
        port2_ri_pin_oe_o |-> port2_ring_indicate_n_o)
        else $error("ring indicate live while pin is kbc line");
    a_dma_follow: assert property (
        ce_i && !dma3_acknowledge_n_o |-> $past(!dma3_ack_pin_i))
        else $error("dma acknowledge not from its pin");
endmodule : mfp_top_sva

// ===== rtl/mfp_pkg.sv
package mfp_pkg;

    // ========================================
    // register map (word addresses, byte offsets)
    localparam logic [7:0] MFP_CTRL_OFS   = 8'h00;
    localparam logic [7:0] MFP_STATUS_OFS = 8'h04;

    // ========================================
    // control field positions
    localparam int MFP_DMA3_SEL_BIT   = 0;
    localparam int MFP_KBCSER_SEL_BIT = 1;
    localparam int MFP_IR_SEL_BIT     = 2;
    localparam int MFP_AQ16_BIT       = 3;
    localparam int MFP_PLL_PD_BIT     = 4;
    localparam int MFP_WAKE_PWR_BIT   = 5;
    localparam int MFP_KBD_RST_BIT    = 6;

    localparam logic [6:0] MFP_CTRL_RST = 7'h10;

    // ========================================
    // status field positions
    localparam int MFP_ST_PLL_ON_BIT  = 0;
    localparam int MFP_ST_GOOD_BIT    = 1;
    localparam int MFP_ST_STRAP_BIT   = 2;
    localparam int MFP_ST_WAKE_BIT    = 3;

    localparam logic [15:0] MFP_CFG_BASE_LO = 16'h03f0;
    localparam logic [15:0] MFP_CFG_BASE_HI = 16'h0370;

    typedef struct packed {
        logic       kbd_rst;
        logic       wake_pwr;
        logic       pll_pd;
        logic       aq16;
        logic       ir_sel;
        logic       kbcser_sel;
        logic       dma3_sel;
    } mfp_ctrl_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } mfp_bus_out_t;

endpackage : mfp_pkg

// ===== rtl/mfp_top.sv
// Contract
// R1 - dma3 pins go to dma or kbc lines b/a per dma3 select; dma default
// R2 - port2 ring/carrier pins go to serial or kbc lines b/a; serial default
// R3 - port2 rx/tx go to uart or infrared per ir bit; uart default
// R4 - 16-bit qualify turns port2 dsr/rts/cts/dtr into address 15,12,13,14
// R5 - in 16-bit qualify mode chip select acts as address 11 in decode
// R6 - supply-good low: host interface idle, no bus cycles decoded
// R7 - wake pins and wake output keep working while supply-good is low
// R8 - wake logic initialised by the standby-plane reset, not host reset
// R9 - pll power-down bit set powers pll down regardless of others
// R10 - pll powered only with pd 0, wake-power 0 and supply-good 1
// R11 - strap low puts config base at 3f0, high at 370
// R12 - keyboard reset output is active low
// R13 - reserved pll combinations keep the pll unpowered
// R14 - after reset all pin-function selects are clear
`timescale 1ns/100ps
module mfp_top
    import mfp_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        standby_rst_i,
    input  wire logic        ce_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // supply and strap
    input  wire logic        supply_good_i,
    input  wire logic        config_base_strap_i,
    // host isa side
    input  wire logic [15:0] isa_addr_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        isa_rd_n_i,
    input  wire logic        isa_wr_n_i,
    output logic             cfg_port_hit_o,
    output logic             host_rd_o,
    output logic             host_wr_o,
    // dma3 / kbc shared pins
    input  wire logic        dma3_ack_pin_i,
    output logic             dma3_req_pin_o,
    output logic             dma3_req_pin_oe_o,
    output logic             dma3_ack_pin_o,
    output logic             dma3_ack_pin_oe_o,
    input  wire logic        dma3_request_i,
    output logic             dma3_acknowledge_n_o,
    // port2 ring/carrier / kbc shared pins
    input  wire logic        port2_ri_pin_i,
    input  wire logic        port2_dcd_pin_i,
    output logic             port2_ri_pin_o,
    output logic             port2_ri_pin_oe_o,
    output logic             port2_dcd_pin_o,
    output logic             port2_dcd_pin_oe_o,
    output logic             port2_ring_indicate_n_o,
    output logic             port2_carrier_detect_n_o,
    // kbc port lines
    input  wire logic        kbc_port_line_a_i,
    input  wire logic        kbc_port_line_b_i,
    output logic             kbc_port_line_a_o,
    output logic             kbc_port_line_b_o,
    // port2 rx/tx pins
    input  wire logic        port2_rx_pin_i,
    output logic             port2_tx_pin_o,
    input  wire logic        uart2_tx_i,
    input  wire logic        infrared_transmit_i,
    output logic             port2_receive_o,
    output logic             infrared_receive_o,
    // port2 modem / high address pins
    input  wire logic        port2_set_ready_pin_i,
    input  wire logic        port2_clear_send_pin_i,
    input  wire logic        port2_request_send_pin_i,
    input  wire logic        port2_terminal_ready_pin_i,
    input  wire logic        port2_request_send_n_i,
    input  wire logic        port2_terminal_ready_n_i,
    output logic             port2_request_send_pin_o,
    output logic             port2_request_send_pin_oe_o,
    output logic             port2_terminal_ready_pin_o,
    output logic             port2_terminal_ready_pin_oe_o,
    output logic             port2_set_ready_n_o,
    output logic             port2_clear_send_n_o,
    // wake sources and output
    input  wire logic        keyboard_data_line_i,
    input  wire logic        mouse_data_line_i,
    input  wire logic        port1_ring_indicate_n_i,
    input  wire logic        wake_enable_i,
    output logic             wake_event_out_n_o,
    // misc
    output logic             pll_power_o,
    output logic             keyboard_reset_out_n_o
);

    // ========================================
    // state
    typedef struct packed {
        mfp_ctrl_t    ctrl;
        mfp_bus_out_t bus;
        logic         strap;
        logic         strap_taken;
        logic         pll_on;
        logic         hit;
        logic         rd;
        logic         wr;
        logic         dma_req;
        logic         dma_req_oe;
        logic         dma_ack;
        logic         dma_ack_oe;
        logic         dma_ack_in;
        logic         ri_pin;
        logic         ri_oe;
        logic         dcd_pin;
        logic         dcd_oe;
        logic         ri_in;
        logic         dcd_in;
        logic         kbc_a;
        logic         kbc_b;
        logic         tx;
        logic         rx_uart;
        logic         rx_ir;
        logic         rts_pin;
        logic         rts_oe;
        logic         dtr_pin;
        logic         dtr_oe;
        logic         dsr_in;
        logic         cts_in;
        logic         kbd_rst_n;
    } mfp_state_t;

    mfp_state_t st_reg;
    mfp_state_t st_next;
    logic       wake_n_reg;

    function automatic logic [15:0] mfp_cfg_base(input logic strap);
        return strap ? MFP_CFG_BASE_HI : MFP_CFG_BASE_LO;   // see R11
    endfunction : mfp_cfg_base

    logic        req;
    logic [15:0] dec_addr;
    logic [15:0] cfg_base;
    logic [31:0] status_word;

    always_comb begin
        st_next = st_reg;
        req     = wb_cyc_i && wb_stb_i && !st_reg.bus.ack;

        // ========================================
        // wishbone slave: one wait state, ack for one cycle
        st_next.bus.ack = req;
        status_word = '0;
        status_word[MFP_ST_PLL_ON_BIT] = st_reg.pll_on;
        status_word[MFP_ST_GOOD_BIT]   = supply_good_i;
        status_word[MFP_ST_STRAP_BIT]  = st_reg.strap;
        status_word[MFP_ST_WAKE_BIT]   = ~wake_n_reg;
        if (req) begin
            st_next.bus.dat = '0;
            if (wb_adr_i == MFP_CTRL_OFS) begin
                st_next.bus.dat = {25'h0, st_reg.ctrl};
                if (wb_we_i && wb_sel_i[0]) begin
                    st_next.ctrl = mfp_ctrl_t'(wb_dat_i[6:0]);
                end
            end else if (wb_adr_i == MFP_STATUS_OFS) begin
                st_next.bus.dat = status_word;
            end
        end

        // strap caught once after reset release
        if (!st_reg.strap_taken) begin
            st_next.strap       = config_base_strap_i;
            st_next.strap_taken = 1'b1;
        end

        // ========================================
        // pll control; reserved combinations stay off
        st_next.pll_on = !st_reg.ctrl.pll_pd                 // see R9
                      && !st_reg.ctrl.wake_pwr && supply_good_i; // see R10 R13

        // ========================================
        // host decode, gated by supply-good
        cfg_base = mfp_cfg_base(st_reg.strap);
        dec_addr = isa_addr_i;
        if (st_reg.ctrl.aq16) begin
            // the select pin is a plain address bit here, not inverted
            dec_addr[11] = chip_select_n_i;                  // see R5
            dec_addr[12] = port2_request_send_pin_i;         // see R4
            dec_addr[13] = port2_clear_send_pin_i;
            dec_addr[14] = port2_terminal_ready_pin_i;
            dec_addr[15] = port2_set_ready_pin_i;
        end else begin
            // 12-bit mode: bits 15:12 ignored, chip select qualifies
            dec_addr[15:12] = cfg_base[15:12];
        end
        st_next.hit = supply_good_i                           // see R6
                   && (st_reg.ctrl.aq16 || !chip_select_n_i)
                   && (dec_addr[15:1] == cfg_base[15:1]);
        st_next.rd = st_next.hit && !isa_rd_n_i;
        st_next.wr = st_next.hit && !isa_wr_n_i;

        // ========================================
        // dma3 pins
        // the request pin is an output in both roles
        st_next.dma_req_oe = 1'b1;                            // see R1
        st_next.dma_req    = st_reg.ctrl.dma3_sel ? kbc_port_line_a_i
                                                  : dma3_request_i;
        st_next.dma_ack_oe = st_reg.ctrl.dma3_sel;
        st_next.dma_ack    = kbc_port_line_b_i;
        st_next.dma_ack_in = st_reg.ctrl.dma3_sel ? 1'b1 : dma3_ack_pin_i;

        // ========================================
        // ring / carrier pins
        st_next.ri_oe   = st_reg.ctrl.kbcser_sel;             // see R2
        st_next.ri_pin  = kbc_port_line_b_i;
        st_next.dcd_oe  = st_reg.ctrl.kbcser_sel;
        st_next.dcd_pin = kbc_port_line_a_i;
        st_next.ri_in   = st_reg.ctrl.kbcser_sel ? 1'b1 : port2_ri_pin_i;
        st_next.dcd_in  = st_reg.ctrl.kbcser_sel ? 1'b1 : port2_dcd_pin_i;
        if (st_reg.ctrl.dma3_sel) begin
            st_next.kbc_a = kbc_port_line_a_i;
            st_next.kbc_b = dma3_ack_pin_i;
        end else if (st_reg.ctrl.kbcser_sel) begin
            st_next.kbc_a = port2_dcd_pin_i;
            st_next.kbc_b = port2_ri_pin_i;
        end else begin
            st_next.kbc_a = 1'b1;
            st_next.kbc_b = 1'b1;
        end

        // ========================================
        // rx/tx: uart receive idles high, infrared receive idles low, on the side not selected
        st_next.tx      = st_reg.ctrl.ir_sel ? infrared_transmit_i
                                             : uart2_tx_i;   // see R3
        st_next.rx_uart = st_reg.ctrl.ir_sel ? 1'b1 : port2_rx_pin_i;
        st_next.rx_ir   = st_reg.ctrl.ir_sel ? port2_rx_pin_i : 1'b0;

        // ========================================
        // modem pins vs high address
        st_next.rts_oe  = !st_reg.ctrl.aq16;                  // see R4
        st_next.dtr_oe  = !st_reg.ctrl.aq16;
        st_next.rts_pin = port2_request_send_n_i;
        st_next.dtr_pin = port2_terminal_ready_n_i;
        st_next.dsr_in  = st_reg.ctrl.aq16 ? 1'b1 : port2_set_ready_pin_i;
        st_next.cts_in  = st_reg.ctrl.aq16 ? 1'b1 : port2_clear_send_pin_i;

        st_next.kbd_rst_n = !st_reg.ctrl.kbd_rst;             // see R12
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg      <= '0;
            st_reg.ctrl <= mfp_ctrl_t'(MFP_CTRL_RST);         // see R14
            st_reg.dma_req_oe <= 1'b1;
            st_reg.dma_ack_in <= 1'b1;
            st_reg.ri_in  <= 1'b1;
            st_reg.dcd_in <= 1'b1;
            st_reg.kbc_a  <= 1'b1;
            st_reg.kbc_b  <= 1'b1;
            st_reg.tx     <= 1'b1;
            st_reg.rx_uart <= 1'b1;
            st_reg.rts_oe <= 1'b1;
            st_reg.dtr_oe <= 1'b1;
            st_reg.rts_pin <= 1'b1;
            st_reg.dtr_pin <= 1'b1;
            st_reg.dsr_in <= 1'b1;
            st_reg.cts_in <= 1'b1;
            st_reg.kbd_rst_n <= 1'b1;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // ========================================
    // wake path: standby reset only, runs whatever supply-good says
    always_ff @(posedge clk_i) begin
        if (standby_rst_i) begin                               // see R8
            wake_n_reg <= 1'b1;
        end else if (ce_i) begin
            wake_n_reg <= !(wake_enable_i && (!keyboard_data_line_i
                          || !mouse_data_line_i
                          || !port1_ring_indicate_n_i
                          || !port2_ri_pin_i
                          || port2_rx_pin_i == 1'b0));        // see R7
        end
    end

    assign wb_dat_o                     = st_reg.bus.dat;
    assign wb_ack_o                     = st_reg.bus.ack;
    assign cfg_port_hit_o               = st_reg.hit;
    assign host_rd_o                    = st_reg.rd;
    assign host_wr_o                    = st_reg.wr;
    assign dma3_req_pin_o               = st_reg.dma_req;
    assign dma3_req_pin_oe_o            = st_reg.dma_req_oe;
    assign dma3_ack_pin_o               = st_reg.dma_ack;
    assign dma3_ack_pin_oe_o            = st_reg.dma_ack_oe;
    assign dma3_acknowledge_n_o         = st_reg.dma_ack_in;
    assign port2_ri_pin_o               = st_reg.ri_pin;
    assign port2_ri_pin_oe_o            = st_reg.ri_oe;
    assign port2_dcd_pin_o              = st_reg.dcd_pin;
    assign port2_dcd_pin_oe_o           = st_reg.dcd_oe;
    assign port2_ring_indicate_n_o      = st_reg.ri_in;
    assign port2_carrier_detect_n_o     = st_reg.dcd_in;
    assign kbc_port_line_a_o            = st_reg.kbc_a;
    assign kbc_port_line_b_o            = st_reg.kbc_b;
    assign port2_tx_pin_o               = st_reg.tx;
    assign port2_receive_o              = st_reg.rx_uart;
    assign infrared_receive_o           = st_reg.rx_ir;
    assign port2_request_send_pin_o     = st_reg.rts_pin;
    assign port2_request_send_pin_oe_o  = st_reg.rts_oe;
    assign port2_terminal_ready_pin_o   = st_reg.dtr_pin;
    assign port2_terminal_ready_pin_oe_o = st_reg.dtr_oe;
    assign port2_set_ready_n_o          = st_reg.dsr_in;
    assign port2_clear_send_n_o         = st_reg.cts_in;
    assign wake_event_out_n_o           = wake_n_reg;
    assign pll_power_o                  = st_reg.pll_on;
    assign keyboard_reset_out_n_o       = st_reg.kbd_rst_n;

endmodule : mfp_top
